/* bcs_battery_model.sv */
// battery pack model: cell and sensor comparator levels seen by the sequencer
module bcs_battery_model (
  input wire present,
  input wire drained,
  input wire hot,
  output wire batt_above_min,
  output wire batt_below_max,
  output wire batt_below_pref,
  output wire temp_above_tmax,
  output wire temp_below_limit
);
  timeunit 1ns;
  timeprecision 100ps;
  // a removed pack leaves the pull-up holding both inputs above their windows
  assign batt_above_min = 1'b1;
  assign batt_below_max = present;
  assign batt_below_pref = present & drained;
  assign temp_above_tmax = ~hot;
  assign temp_below_limit = present;
endmodule // bcs_battery_model

/* bcs_checker.sv */
// assertion checker watching the charge sequencer ports
module bcs_checker (
  input wire ref_clk,
  input wire arst_n,
  input wire batt_above_min,
  input wire batt_below_max,
  input wire batt_below_pref,
  input wire temp_above_tmax,
  input wire temp_below_limit,
  input wire slope_plausible,
  input wire drop_detected,
  input wire [2:0] charge_rate,
  input wire red_indicator,
  input wire green_indicator,
  input wire formation_active,
  input wire drop_enable,
  input wire slope_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire win = batt_above_min && batt_below_max;
  wire ok = win && temp_above_tmax && temp_below_limit;
  a_window_stop: assert property (!win |-> ##[1:3] charge_rate == 3'h0)
    else $error("charging without battery window");
  a_temp_stop: assert property (win && !ok |-> ##[1:3] charge_rate == 3'h0)
    else $error("charging with sensor outside window");
  a_form_no_slope: assert property (formation_active |-> !slope_enable)
    else $error("slope detection live in formation");
  a_form_drop_on: assert property (formation_active |-> drop_enable)
    else $error("drop detection off in formation");
  a_form_drop_end: assert property (formation_active && drop_detected && ok
    |-> ##[1:3] charge_rate == 3'h2) else $error("drop did not end fast charge");
  a_slope_ends_fast: assert property (slope_enable && slope_plausible && ok
    |-> ##[1:3] charge_rate == 3'h2) else $error("slope did not end fast charge");
  a_pref_to_fast: assert property (charge_rate == 3'h5 && ok && !batt_below_pref
    |-> ##[1:3] charge_rate == 3'h1) else $error("reference reached, no fast charge");
  a_topoff_no_drop: assert property (charge_rate == 3'h2 |-> !drop_enable)
    else $error("drop detection live in top-off");
  a_trickle_leds: assert property (charge_rate == 3'h4 |-> green_indicator && !red_indicator)
    else $error("wrong indicators in trickle");
endmodule // bcs_checker

/* bcs_regs.vh */
// constants and timing for the battery charge sequencer
// Operation
// R1 - drained cell in window: slow preformation charge
// R2 - green blinks first ten preformation minutes
// R3 - still low after ten minutes: red blinks
// R4 - reference reached: fast charge, green blinks
// R5 - fast charge needs battery voltage window
// R6 - fast charge needs temperature sensor window
// R7 - slope detection suppressed first five minutes
// R8 - only drop detection during formation phase
// R9 - temperature checked in every charge phase
// R10 - slope or drop ends fast charge
// R11 - top-off follows at quarter rate
// R12 - trickle at one 256th afterwards
// R13 - low-cost: drop ends top-off, trickle sixteenth
// R14 - others: no drop check, full top-off
// R15 - two-LED indicator table
// R16 - preformation variant indicator table
// R17 - four-output variant indicator table
// R18 - all durations derived from oscillator ticks
// R19 - low-cost restarts only on reinsertion
// R20 - low-cost skips top-off phase
// R21 - blink from fixed oscillator division
`ifndef BCS_REGS_VH
`define BCS_REGS_VH
`define BCS_CLK_HZ 40000000
`define BCS_OSC_HZ 800
`define BCS_OSC_DIV (`BCS_CLK_HZ / `BCS_OSC_HZ)
`define BCS_FORM_MIN 5
`define BCS_PREF_MIN 10
`define BCS_TOPOFF_MIN 20
`define BCS_MIN_TICKS (60 * `BCS_OSC_HZ)
`define BCS_BLINK_TICKS 400
`define BCS_VAR_LOWCOST 2'h0
`define BCS_VAR_STD 2'h1
`define BCS_VAR_PREF 2'h2
`define BCS_VAR_FOUR 2'h3
`define BCS_RATE_OFF 3'h0
`define BCS_RATE_FAST 3'h1
`define BCS_RATE_QUARTER 3'h2
`define BCS_RATE_SIXTEENTH 3'h3
`define BCS_RATE_TRICKLE 3'h4
`define BCS_RATE_PREF 3'h5
`endif

/* bcs_sequencer.v */
// charge sequencer: phase state machine, phase timers and indicator drive
`include "bcs_regs.vh"
module bcs_sequencer #(
  parameter [1:0] VARIANT = `BCS_VAR_STD,
  parameter OSC_DIV = `BCS_OSC_DIV,
  parameter FORM_TICKS = `BCS_FORM_MIN * `BCS_MIN_TICKS,
  parameter PREF_TICKS = `BCS_PREF_MIN * `BCS_MIN_TICKS,
  parameter TOPOFF_TICKS = `BCS_TOPOFF_MIN * `BCS_MIN_TICKS,
  parameter BLINK_TICKS = `BCS_BLINK_TICKS
) (
  input wire ref_clk,
  input wire arst_n,
  input wire power_on_pulse,
  input wire batt_above_min,
  input wire batt_below_max,
  input wire batt_below_pref,
  input wire temp_above_tmax,
  input wire temp_below_limit,
  input wire slope_plausible,
  input wire drop_detected,
  input wire batt_fault,
  output reg [2:0] charge_rate,
  output reg red_indicator,
  output reg green_indicator,
  output reg status_output_three,
  output reg status_output_four,
  output reg formation_active,
  output reg drop_enable,
  output reg slope_enable
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_PREF = 7'h02;
  localparam [6:0] S_FAST = 7'h04;
  localparam [6:0] S_TOPOFF = 7'h08;
  localparam [6:0] S_TRICKLE = 7'h10;
  localparam [6:0] S_TEMP = 7'h20;
  localparam [6:0] S_FAIL = 7'h40;
  // terminal counts are worked out wide, then cut to the counter widths on purpose
  localparam integer DIV_LAST_W = OSC_DIV - 1;
  localparam integer BLINK_LAST_W = BLINK_TICKS - 1;
  localparam [15:0] DIV_LAST = DIV_LAST_W[15:0];
  // phase timer must hold the twenty-minute top-off count at the oscillator rate
  localparam [19:0] TIMER_ZERO = 20'h00000;
  localparam [19:0] TIMER_MAX = 20'hfffff;
  localparam [9:0] BLINK_LAST = BLINK_LAST_W[9:0];

  reg [6:0] state;
  reg [6:0] next_state;
  reg [15:0] div_cnt;
  reg osc_tick;
  reg [9:0] blink_cnt;
  reg blink;
  reg [19:0] phase_timer;
  reg [2:0] next_rate;
  reg next_red;
  reg next_green;
  reg next_three;
  reg next_four;
  reg pref_late;
  reg seen_insert;
  reg early_temp;
  reg batt_present_d;

  wire batt_in_window = batt_above_min & batt_below_max; // [R5]
  wire temp_ok = temp_above_tmax & temp_below_limit; // [R6]
  wire has_pref = (VARIANT == `BCS_VAR_PREF) || (VARIANT == `BCS_VAR_FOUR);
  wire low_cost = (VARIANT == `BCS_VAR_LOWCOST);
  wire insert_edge = batt_in_window & ~batt_present_d;
  // power-on restart ignored in low-cost part [R19]
  wire restart = insert_edge | (power_on_pulse & ~low_cost);
  wire form_done = phase_timer >= FORM_TICKS;

  // fast-charge decode shared by the formation and detector enables
  function is_fast;
    input [6:0] s;
    begin
      is_fast = (s == S_FAST);
    end
  endfunction

  // one-tick-per-oscillator-period enable, every duration counts these [R18]
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 16'h0000;
      osc_tick <= 1'b0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= 16'h0000;
      osc_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      osc_tick <= 1'b0;
    end
  end

  // even duty blink from a fixed oscillator division [R21]
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt <= 10'h000;
      blink <= 1'b0;
    end else if (osc_tick) begin
      if (blink_cnt == BLINK_LAST) begin
        blink_cnt <= 10'h000;
        blink <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 10'h001;
      end
    end
  end

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (restart) begin
          if (!temp_ok) begin
            next_state = S_TEMP;
          end else if (has_pref && batt_below_pref) begin
            next_state = S_PREF; // [R1]
          end else begin
            next_state = S_FAST; // [R5] [R6]
          end
        end
      end
      S_PREF: begin
        if (!temp_ok) begin
          next_state = S_TEMP; // [R9]
        end else if (!batt_below_pref) begin
          next_state = S_FAST; // [R4]
        end
      end
      S_FAST: begin
        if (!temp_ok) begin
          next_state = S_TEMP; // [R9]
        end else if (batt_fault) begin
          next_state = S_FAIL;
        end else if (drop_detected || (form_done && slope_plausible)) begin
          // drop always armed, slope only after formation [R8] [R10]
          next_state = low_cost ? S_TRICKLE : S_TOPOFF; // [R11] [R20]
        end
      end
      S_TOPOFF: begin
        if (!temp_ok) begin
          next_state = S_TEMP; // [R9]
        end else if (phase_timer >= TOPOFF_TICKS) begin
          next_state = S_TRICKLE; // [R14]
        end else if (low_cost && drop_detected) begin
          next_state = S_TRICKLE; // [R13]
        end
      end
      S_TRICKLE: begin
        if (!temp_ok) begin
          next_state = S_TEMP; // [R9]
        end
      end
      S_TEMP: begin
        if (temp_ok) begin
          next_state = S_IDLE;
        end
      end
      S_FAIL: next_state = S_FAIL;
      default: next_state = S_IDLE;
    endcase
    // removal of the battery always drops back to waiting for insertion
    if (!batt_in_window && state != S_IDLE) begin
      next_state = S_IDLE;
    end
    if (restart && state != S_IDLE) begin
      next_state = S_IDLE;
    end
  end

  // temperature fault caught before the first charge start gives its own pattern, except in the four-output variant
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      batt_present_d <= 1'b0;
      phase_timer <= TIMER_ZERO;
      pref_late <= 1'b0;
      seen_insert <= 1'b0;
      early_temp <= 1'b0;
    end else begin
      state <= next_state;
      batt_present_d <= batt_in_window;
      if (next_state != state) begin
        phase_timer <= TIMER_ZERO;
      end else if (osc_tick && phase_timer != TIMER_MAX) begin
        phase_timer <= phase_timer + 20'h00001;
      end
      if (state != S_PREF) begin
        pref_late <= 1'b0;
      end else if (phase_timer >= PREF_TICKS) begin
        pref_late <= 1'b1; // [R3]
      end
      if (next_state == S_FAST || next_state == S_PREF) begin
        seen_insert <= 1'b1;
      end else if (!batt_in_window) begin
        seen_insert <= 1'b0;
      end
      if (next_state == S_TEMP && state == S_IDLE && !seen_insert) begin
        early_temp <= 1'b1;
      end else if (next_state != S_TEMP) begin
        early_temp <= 1'b0;
      end
    end
  end

  // charge rate decoded from the present state
  always @* begin
    next_rate = `BCS_RATE_OFF;
    case (state)
      S_PREF: begin
        next_rate = `BCS_RATE_PREF; // [R1]
      end
      S_FAST: begin
        next_rate = `BCS_RATE_FAST; // [R4]
      end
      S_TOPOFF: begin
        next_rate = `BCS_RATE_QUARTER; // [R11]
      end
      S_TRICKLE: begin
        next_rate = low_cost ? `BCS_RATE_SIXTEENTH : `BCS_RATE_TRICKLE; // [R12] [R13]
      end
      default: begin
        next_rate = `BCS_RATE_OFF;
      end
    endcase
  end

  // indicator pattern per variant; all dark unless the state lights one
  always @* begin
    next_red = 1'b0;
    next_green = 1'b0;
    next_three = 1'b0;
    next_four = 1'b0;
    if (VARIANT == `BCS_VAR_FOUR) begin
      case (state) // [R17]
        S_PREF: begin
          next_red = pref_late ? blink : 1'b0;
        end
        S_FAST: begin
          next_three = blink;
        end
        S_TOPOFF: begin
          next_green = 1'b1;
          next_four = 1'b1;
        end
        S_TRICKLE: begin
          next_green = 1'b1;
        end
        S_TEMP: begin
          next_red = blink;
        end
        S_FAIL: begin
          next_red = blink;
        end
        default: begin
          next_green = 1'b0;
        end
      endcase
    end else if (VARIANT == `BCS_VAR_PREF) begin
      case (state) // [R16]
        S_PREF: begin
          next_green = pref_late ? 1'b0 : blink; // [R2]
          next_red = pref_late ? blink : 1'b0; // [R3]
        end
        S_FAST: begin
          next_green = blink; // [R4]
        end
        S_TOPOFF: begin
          next_green = 1'b1;
        end
        S_TRICKLE: begin
          next_green = 1'b1;
        end
        S_TEMP: begin
          next_red = 1'b1;
          next_green = early_temp ? blink : 1'b0;
        end
        S_FAIL: begin
          next_red = blink;
        end
        default: begin
          next_green = 1'b0;
        end
      endcase
    end else begin
      case (state) // [R15]
        S_IDLE: begin
          next_green = 1'b1;
        end
        S_FAST: begin
          next_green = blink;
        end
        S_TOPOFF: begin
          next_green = 1'b1;
        end
        S_TRICKLE: begin
          next_green = 1'b1;
        end
        S_TEMP: begin
          next_red = ~early_temp;
          next_green = early_temp ? blink : 1'b0;
        end
        S_FAIL: begin
          next_red = blink;
        end
        default: begin
          next_green = 1'b0;
        end
      endcase
    end
  end

  // outputs registered from the present state
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_rate <= `BCS_RATE_OFF;
      red_indicator <= 1'b0;
      green_indicator <= 1'b0;
      status_output_three <= 1'b0;
      status_output_four <= 1'b0;
      formation_active <= 1'b0;
      drop_enable <= 1'b0;
      slope_enable <= 1'b0;
    end else begin
      formation_active <= is_fast(state) && !form_done; // [R7]
      slope_enable <= is_fast(state) && form_done; // [R7]
      drop_enable <= is_fast(state) || (low_cost && state == S_TOPOFF); // [R8] [R13] [R14]
      charge_rate <= next_rate;
      red_indicator <= next_red;
      green_indicator <= next_green;
      status_output_three <= next_three;
      status_output_four <= next_four;
    end
  end
endmodule // bcs_sequencer

/* bcs_sequencer_tb.sv */
// self-checking bench for the charge sequencer, preformation variant
`include "bcs_regs.vh"
module bcs_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  reg ref_clk = 1'b0;
  reg arst_n = 1'b0;
  reg present = 1'b0, drained = 1'b0, hot = 1'b0, slope = 1'b0, drop = 1'b0;
  reg pwr = 1'b0, flt = 1'b0;
  wire b_min, b_max, b_pref, t_max, t_lim, red, green, s3, s4, form, d_en, s_en;
  wire [2:0] charge_rate;
  integer fails = 0, n_tests = 0, g_tog, r_tog;
  always #12.5 ref_clk = ~ref_clk;
  bcs_battery_model pack_u (.present(present), .drained(drained), .hot(hot),
    .batt_above_min(b_min), .batt_below_max(b_max), .batt_below_pref(b_pref),
    .temp_above_tmax(t_max), .temp_below_limit(t_lim));
  // short timers keep the run brief: osc tick 4 clocks, blink toggles every 8
  bcs_sequencer #(.VARIANT(`BCS_VAR_PREF), .OSC_DIV(4), .FORM_TICKS(20), .PREF_TICKS(40),
    .TOPOFF_TICKS(80), .BLINK_TICKS(2)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .power_on_pulse(pwr), .batt_above_min(b_min), .batt_below_max(b_max),
    .batt_below_pref(b_pref), .temp_above_tmax(t_max), .temp_below_limit(t_lim),
    .slope_plausible(slope), .drop_detected(drop), .batt_fault(flt),
    .charge_rate(charge_rate), .red_indicator(red), .green_indicator(green),
    .status_output_three(s3), .status_output_four(s4), .formation_active(form),
    .drop_enable(d_en), .slope_enable(s_en));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  task rate_is(input [2:0] exp);
    check({29'h0, charge_rate}, {29'h0, exp});
  endtask
  task leds_are(input [3:0] exp);
    check({28'h0, red, green, s3, s4}, {28'h0, exp});
  endtask
  // expects {green toggled, red toggled} over 40 cycles
  task blinks_are(input [1:0] exp);
    reg g0, r0;
    begin
      g_tog = 0;
      r_tog = 0;
      repeat (40) begin
        g0 = green;
        r0 = red;
        cyc(1);
        if (green !== g0) g_tog = g_tog + 1;
        if (red !== r0) r_tog = r_tog + 1;
      end
      check({30'h0, g_tog != 0, r_tog != 0}, {30'h0, exp});
    end
  endtask
  task t_drained;
    begin
      present = 1'b1;
      drained = 1'b1;
      cyc(4);
      rate_is(`BCS_RATE_PREF);
      blinks_are(2'b10);
      cyc(160);
      rate_is(`BCS_RATE_PREF);
      blinks_are(2'b01);
      drained = 1'b0;
      cyc(4);
      rate_is(`BCS_RATE_FAST);
      blinks_are(2'b10);
    end
  endtask
  task t_full_cycle;
    begin
      present = 1'b0;
      cyc(4);
      rate_is(`BCS_RATE_OFF);
      leds_are(4'b0000);
      present = 1'b1;
      slope = 1'b1;
      cyc(4);
      rate_is(`BCS_RATE_FAST);
      check({30'h0, form, s_en}, 32'h2);
      cyc(100);
      rate_is(`BCS_RATE_QUARTER);
      slope = 1'b0;
      drop = 1'b1;
      cyc(20);
      rate_is(`BCS_RATE_QUARTER);
      leds_are(4'b0100);
      cyc(320);
      drop = 1'b0;
      rate_is(`BCS_RATE_TRICKLE);
      hot = 1'b1;
      cyc(4);
      rate_is(`BCS_RATE_OFF);
      leds_are(4'b1000);
      hot = 1'b0;
    end
  endtask
  task t_early_drop_and_temp;
    begin
      present = 1'b0;
      cyc(4);
      present = 1'b1;
      cyc(4);
      check({31'h0, d_en}, 32'h1);
      drop = 1'b1;
      cyc(4);
      rate_is(`BCS_RATE_QUARTER);
      drop = 1'b0;
      present = 1'b0;
      cyc(4);
      hot = 1'b1;
      present = 1'b1;
      cyc(4);
      rate_is(`BCS_RATE_OFF);
      check({31'h0, red}, 32'h1);
      blinks_are(2'b10);
    end
  endtask
  task t_fault_and_power_on;
    begin
      hot = 1'b0;
      cyc(4);
      rate_is(`BCS_RATE_OFF);
      pwr = 1'b1;
      cyc(1);
      pwr = 1'b0;
      cyc(4);
      rate_is(`BCS_RATE_FAST);
      flt = 1'b1;
      cyc(4);
      flt = 1'b0;
      rate_is(`BCS_RATE_OFF);
      blinks_are(2'b01);
    end
  endtask
  initial begin
    cyc(4);
    arst_n = 1'b1;
    t_drained;
    t_full_cycle;
    t_early_drop_and_temp;
    t_fault_and_power_on;
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails = fails + 1;
    give_verdict;
  end
endmodule // bcs_sequencer_tb
bind bcs_sequencer bcs_checker chk_u (.ref_clk(ref_clk), .arst_n(arst_n),
  .batt_above_min(batt_above_min), .batt_below_max(batt_below_max),
  .batt_below_pref(batt_below_pref), .temp_above_tmax(temp_above_tmax),
  .temp_below_limit(temp_below_limit), .slope_plausible(slope_plausible),
  .drop_detected(drop_detected), .charge_rate(charge_rate), .red_indicator(red_indicator),
  .green_indicator(green_indicator), .formation_active(formation_active),
  .drop_enable(drop_enable), .slope_enable(slope_enable));
